// File: design/flash_wp_pkg.sv
package flash_wp_pkg;

  // instruction codes seen by the protection logic
  localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_SECTOR_LOCK_WRITE = 8'hE5;
  localparam logic [7:0] CMD_SECTOR_LOCK_READ = 8'hE8;
  localparam logic [7:0] CMD_OTP_PROGRAM = 8'h42;
  localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
  localparam logic [7:0] CMD_DUAL_IN_PAGE_WRITE = 8'hA2;
  localparam logic [7:0] CMD_ERASE_4K = 8'h20;
  localparam logic [7:0] CMD_BLOCK64K_WIPE = 8'hD8;
  localparam logic [7:0] CMD_WHOLE_ARRAY_WIPE = 8'hC7;
  localparam logic [7:0] CMD_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] CMD_WAKE_FROM_SLEEP = 8'hAB;

  // arbitrary neutral identity value, not a real part code
  localparam logic [15:0] DEVICE_ID_CODE = 16'h0A5A;

  localparam int NUM_SECTORS = 32;
  localparam int SECTOR_BITS = 5;
  localparam int ADDR_BITS = 21;
  localparam int SECTOR_LSB = 16;
  localparam logic [2:0] BIT_COUNT_MASK = 3'h7;
  localparam logic [2:0] RANGE_NONE = 3'h0;
  localparam logic [2:0] RANGE_ALL_MIN = 3'h6;

  // status bit positions
  localparam int ST_RUN = 0;
  localparam int ST_WEL = 1;
  localparam int ST_RS0 = 2;
  localparam int ST_RS1 = 3;
  localparam int ST_RS2 = 4;
  localparam int ST_TB = 5;
  localparam int ST_FRZ = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // lock register field positions
  localparam int LK_WRITE = 0;
  localparam int LK_DOWN = 1;

  // power-up write delay: time in us, cycles at 10 MHz
  localparam int CLK_MHZ = 10;
  localparam int POWERUP_WRITE_DELAY_US = 1000;
  localparam int POWERUP_WRITE_DELAY_CYC = POWERUP_WRITE_DELAY_US * CLK_MHZ;

  // one decoded instruction handed from the link domain
  typedef struct packed {
    logic [7:0] opcode;          // instruction byte
    logic [ADDR_BITS-1:0] addr;  // address field
    logic [7:0] data;            // last data byte
    logic byte_aligned;          // clock count was a multiple of eight
  } frame_t;

  typedef enum logic [1:0] {
    PWR_STANDBY = 2'b00,
    PWR_ACTIVE = 2'b01,
    PWR_DEEP = 2'b10
  } pwr_state_t;

endpackage : flash_wp_pkg

// File: design/frame_capture.sv
`timescale 1ns/1ps
// link-side shifter: collects one frame per select, in the serial clock domain
module frame_capture
  import flash_wp_pkg::*;
(
  input wire logic sclk,           // serial clock from host
  input wire logic cs_n,           // chip select, active low
  input wire logic mosi,           // serial data in
  output logic [39:0] shift_q,     // collected bits, msb first
  output logic [2:0] bit_cnt_q,    // bit count modulo eight
  output logic [5:0] total_q,      // bits seen, saturating
  output logic frame_tgl_q         // set at each frame end if the frame carried clock pulses
);

  logic [2:0] cnt_q;   // running count modulo eight
  logic [5:0] tot_q;   // running total, saturating

  ////////////////////////////////////////////////////////////////////////
  // shift on rising sclk; select high clears the count asynchronously
  // since sclk stands still between frames
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= 3'h0;
      tot_q <= 6'h00;
    end else begin
      shift_q <= {shift_q[38:0], mosi};
      cnt_q <= cnt_q + 3'h1;
      if (tot_q != 6'h3F) begin
        tot_q <= tot_q + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // deselect edge keeps the finished frame's counts; the running ones
  // are cleared at that same edge, so the core must read these copies
  always_ff @(posedge cs_n) begin
    bit_cnt_q <= cnt_q;
    total_q <= tot_q;
    frame_tgl_q <= (tot_q != 6'h00);  // frame carried clock pulses
  end

endmodule : frame_capture

// File: design/flash_write_guard.sv
`timescale 1ns/1ps
// Overview of operation
// - select low keeps device active
// - deselect waits for running cycle, then standby
// - deep sleep until wake instruction
// - deep sleep ignores all modifying instructions
// - modify needs clock count multiple of eight
// - unlock sets latch; clear latch blocks modify
// - latch cleared at reset and listed completions
// - block modify until power-up delay expires
// - per-sector lock register, readable and writable
// - write-lock bit one blocks sector modify
// - lock-down freezes sector lock until power-up
// - bottom-side ranges counted from sector 0
// - top-side ranges counted from sector 31
// - either protection refuses the modification
// - protect pin freezes range and freeze bits
// - bulk wipe only with range code zero
// - running flag set during write cycles
module flash_write_guard
  import flash_wp_pkg::*;
#(
  parameter int POWERUP_CYC = POWERUP_WRITE_DELAY_CYC  // shortenable delay
) (
  input wire logic core_clk,           // core clock, 10 MHz
  input wire logic nrst,               // sync reset, active low
  input wire logic sclk,               // serial clock from host
  input wire logic cs_n,               // chip select, active low
  input wire logic mosi,               // serial data in
  input wire logic wp_n,               // write protect pin, active low
  input wire logic cycle_done,         // array reports cycle finished
  output logic active_q,               // active power state
  output logic deep_sleep_q,           // deep power-down state
  output logic [7:0] status_q,         // status register image
  output logic [1:0] lock_rd_q,        // lock bits for last lock read
  output logic modify_go_q,            // pulse: start array operation
  output logic [7:0] modify_op_q,      // opcode of started operation
  output logic [ADDR_BITS-1:0] modify_addr_q,  // its address
  output logic refused_q               // pulse: modification refused
);

  ////////////////////////////////////////////////////////////////////////
  // link side
  logic [39:0] shift_w;       // captured frame bits
  logic [2:0] bit_cnt_w;      // count modulo eight
  logic [5:0] total_w;        // total bits
  logic frame_tgl_w;          // frame carried clock pulses

  frame_capture u_cap (
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .shift_q(shift_w),
    .bit_cnt_q(bit_cnt_w),
    .total_q(total_w),
    .frame_tgl_q(frame_tgl_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // crossings: select and pin as levels, frame end from synced deselect edge
  logic [2:0] cs_sync_q;      // select synchroniser plus edge stage
  logic [1:0] wp_sync_q;      // protect pin synchroniser

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cs_sync_q <= 3'b111;    // idle level, no false edge after reset
      wp_sync_q <= 2'b11;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], cs_n};
      wp_sync_q <= {wp_sync_q[0], wp_n};
    end
  end

  logic cs_n_s;               // synced select
  logic wp_n_s;               // synced protect pin
  logic frame_end;            // one pulse per finished frame
  assign cs_n_s = cs_sync_q[1];
  assign wp_n_s = wp_sync_q[1];
  // deselect edge of a frame that carried clocks; the held counts are
  // settled long before the synced edge lands
  assign frame_end = cs_sync_q[1] && !cs_sync_q[2] && frame_tgl_w;

  ////////////////////////////////////////////////////////////////////////
  // frame decode; link data is stable long before the synced deselect edge lands,
  // because sclk stands still once select is high
  frame_t fr;                 // decoded frame
  logic [5:0] nbits;          // bits in this frame
  always_comb begin
    nbits = total_w;
    fr.byte_aligned = (bit_cnt_w & BIT_COUNT_MASK) == 3'h0;
    fr.opcode = 8'h00;
    fr.addr = '0;
    fr.data = 8'h00;
    case (nbits)
      6'h08: fr.opcode = shift_w[7:0];
      6'h10: begin
        fr.opcode = shift_w[15:8];
        fr.data = shift_w[7:0];
      end
      6'h20: begin
        fr.opcode = shift_w[31:24];
        fr.addr = shift_w[ADDR_BITS-1:0];
      end
      default: begin
        if (nbits >= 6'h08 && nbits < 6'h28) begin
          // odd lengths: opcode is still the first byte sent
          fr.opcode = shift_w[nbits - 6'h01 -: 8];
        end else begin
          // longer frames: opcode and address, then the last data byte
          fr.opcode = shift_w[39:32];
          fr.addr = shift_w[ADDR_BITS+7:8];
          fr.data = shift_w[7:0];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // helper functions used by several decisions
  function automatic logic is_modify(input logic [7:0] op);
    is_modify = (op == CMD_STATUS_WRITE) || (op == CMD_SECTOR_LOCK_WRITE)
      || (op == CMD_OTP_PROGRAM) || (op == CMD_PAGE_WRITE)
      || (op == CMD_DUAL_IN_PAGE_WRITE) || (op == CMD_ERASE_4K)
      || (op == CMD_BLOCK64K_WIPE) || (op == CMD_WHOLE_ARRAY_WIPE);
  endfunction : is_modify

  function automatic logic is_array_op(input logic [7:0] op);
    is_array_op = (op == CMD_PAGE_WRITE) || (op == CMD_DUAL_IN_PAGE_WRITE)
      || (op == CMD_ERASE_4K) || (op == CMD_BLOCK64K_WIPE);
  endfunction : is_array_op

  // range protection of one sector from range code and side select
  function automatic logic range_hit(input logic [2:0] code,
                                     input logic tb,
                                     input logic [SECTOR_BITS-1:0] sec);
    logic [SECTOR_BITS-1:0] idx;
    logic [SECTOR_BITS:0] span;
    idx = tb ? sec : ~sec;           // distance from protected end
    span = 6'h01 << (code - 3'h1);
    if (code == RANGE_NONE) begin
      range_hit = 1'b0;
    end else if (code >= RANGE_ALL_MIN) begin
      range_hit = 1'b1;
    end else begin
      range_hit = {1'b0, idx} < span;
    end
  endfunction : range_hit

  ////////////////////////////////////////////////////////////////////////
  // power-up write delay counter
  logic [$clog2(POWERUP_CYC+1)-1:0] pu_cnt_q;  // cycles since reset
  logic pu_done_q;                              // delay expired
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pu_cnt_q <= '0;
      pu_done_q <= 1'b0;
    end else if (!pu_done_q) begin
      pu_cnt_q <= pu_cnt_q + 1'b1;
      if (pu_cnt_q == ($clog2(POWERUP_CYC+1))'(POWERUP_CYC - 1)) begin
        pu_done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock registers, one per sector
  logic [1:0] lock_q [NUM_SECTORS];  // write-lock and lock-down bits
  logic [SECTOR_BITS-1:0] sec;       // addressed sector
  assign sec = fr.addr[SECTOR_LSB +: SECTOR_BITS];

  ////////////////////////////////////////////////////////////////////////
  // acceptance decision for the current frame
  logic frozen;               // status register read-only
  logic blocked;              // generic modify block
  logic sec_prot;             // addressed sector protected
  logic accept;               // modification goes ahead
  always_comb begin
    frozen = status_q[ST_FRZ] && !wp_n_s;
    sec_prot = lock_q[sec][LK_WRITE]
      || range_hit(status_q[ST_RS2:ST_RS0], status_q[ST_TB], sec);
    blocked = deep_sleep_q
      || !fr.byte_aligned
      || !status_q[ST_WEL]
      || !pu_done_q
      || status_q[ST_RUN];
    accept = !blocked;
    if (is_array_op(fr.opcode) && sec_prot) begin
      accept = 1'b0;
    end
    if (fr.opcode == CMD_WHOLE_ARRAY_WIPE
        && status_q[ST_RS2:ST_RS0] != RANGE_NONE) begin
      accept = 1'b0;
    end
    if (fr.opcode == CMD_SECTOR_LOCK_WRITE && lock_q[sec][LK_DOWN]) begin
      accept = 1'b0;
    end
  end

  logic take;                 // modifying frame accepted this cycle
  assign take = frame_end && is_modify(fr.opcode) && accept;

  ////////////////////////////////////////////////////////////////////////
  // lock register writes and reads
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_SECTORS; i++) begin
        lock_q[i] <= 2'b00;
      end
      lock_rd_q <= 2'b00;
    end else if (frame_end && !deep_sleep_q) begin
      if (take && fr.opcode == CMD_SECTOR_LOCK_WRITE) begin
        lock_q[sec] <= {fr.data[LK_DOWN], fr.data[LK_WRITE]};
      end
      if (fr.opcode == CMD_SECTOR_LOCK_READ) begin
        lock_rd_q <= lock_q[sec];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status register: latch, running flag, range bits
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      status_q <= STATUS_RESET;
    end else begin
      if (cycle_done) begin
        status_q[ST_RUN] <= 1'b0;
      end
      if (frame_end && !deep_sleep_q && fr.byte_aligned) begin
        if (fr.opcode == CMD_WRITE_UNLOCK) begin
          status_q[ST_WEL] <= 1'b1;
        end
        if (fr.opcode == CMD_WRITE_LOCK) begin
          status_q[ST_WEL] <= 1'b0;
        end
      end
      if (take) begin
        status_q[ST_WEL] <= 1'b0;
        // set wins over a done in the same cycle
        status_q[ST_RUN] <= 1'b1;
        if (fr.opcode == CMD_STATUS_WRITE && !frozen) begin
          status_q[ST_RS2:ST_RS0] <= fr.data[ST_RS2:ST_RS0];
          status_q[ST_TB] <= fr.data[ST_TB];
          status_q[ST_FRZ] <= fr.data[ST_FRZ];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array operation hand-off and refusal report
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      modify_go_q <= 1'b0;
      modify_op_q <= 8'h00;
      modify_addr_q <= '0;
      refused_q <= 1'b0;
    end else begin
      modify_go_q <= take;
      refused_q <= frame_end && is_modify(fr.opcode) && !accept;
      if (take) begin
        modify_op_q <= fr.opcode;
        modify_addr_q <= fr.addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state machine
  pwr_state_t pwr_q;          // current power state
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pwr_q <= PWR_STANDBY;
    end else begin
      case (pwr_q)
        PWR_STANDBY: begin
          if (frame_end && fr.opcode == CMD_DEEP_SLEEP) begin
            pwr_q <= PWR_DEEP;
          end else if (!cs_n_s) begin
            pwr_q <= PWR_ACTIVE;
          end
        end
        PWR_ACTIVE: begin
          if (frame_end && fr.opcode == CMD_DEEP_SLEEP && fr.byte_aligned) begin
            pwr_q <= PWR_DEEP;
          end else if (cs_n_s && !status_q[ST_RUN] && !take) begin
            pwr_q <= PWR_STANDBY;
          end
        end
        PWR_DEEP: begin
          if (frame_end && fr.opcode == CMD_WAKE_FROM_SLEEP) begin
            pwr_q <= PWR_STANDBY;
          end
        end
        default: pwr_q <= PWR_STANDBY;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      active_q <= 1'b0;
      deep_sleep_q <= 1'b0;
    end else begin
      active_q <= (pwr_q == PWR_ACTIVE) || (!cs_n_s && pwr_q != PWR_DEEP);
      deep_sleep_q <= (pwr_q == PWR_DEEP);
    end
  end

endmodule : flash_write_guard

// File: verification/flash_write_guard_chk.sv
`timescale 1ns/1ps
module flash_write_guard_chk
  import flash_wp_pkg::*;
#(
  parameter int POWERUP_CYC = 4  // delay handed on from the design
) (
  input wire logic core_clk,           // core clock
  input wire logic nrst,               // sync reset, active low
  input wire logic cs_n,               // select, active low
  input wire logic active_q,           // active power state
  input wire logic deep_sleep_q,       // deep power-down state
  input wire logic [7:0] status_q,     // status image
  input wire logic modify_go_q,        // start pulse
  input wire logic [7:0] modify_op_q,  // started opcode
  input wire logic refused_q           // refuse pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////
  // cycles since reset release, saturating so it never wraps
  int up_q;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      up_q <= 0;
    end else if (up_q < POWERUP_CYC + 2) begin
      up_q <= up_q + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // cs_n is async, so allow the synchroniser some cycles
  AST_SEL_ACTIVE: assert property ((!cs_n && !deep_sleep_q) [*5] |-> active_q)
    else $error("selected device not active");
  AST_IDLE_STANDBY: assert property ((cs_n && !status_q[0]) [*8] |-> !active_q)
    else $error("idle deselected device still active");
  AST_GO_AWAKE: assert property (modify_go_q |-> !$past(deep_sleep_q))
    else $error("operation started in deep sleep");
  AST_GO_PULSE: assert property (modify_go_q |=> !modify_go_q && !refused_q)
    else $error("start pulse longer than one cycle");
  AST_GO_LATCH: assert property ($rose(modify_go_q) |-> $past(status_q[1]))
    else $error("operation started with latch clear");
  AST_GO_CLEAR: assert property (modify_go_q |-> !status_q[1] && status_q[0])
    else $error("latch or running flag wrong at start");
  AST_POWERUP: assert property (modify_go_q |-> up_q >= POWERUP_CYC)
    else $error("operation started before power-up delay");
  AST_EXCL: assert property (!(modify_go_q && refused_q))
    else $error("start and refuse together");
  AST_BULK: assert property (modify_go_q && modify_op_q == CMD_WHOLE_ARRAY_WIPE
    |-> $past(status_q[4:2]) == 3'h0)
    else $error("bulk wipe with range set");
  AST_OP_HOLD: assert property (!modify_go_q |-> $stable(modify_op_q))
    else $error("opcode changed without start");
endmodule : flash_write_guard_chk

bind flash_write_guard flash_write_guard_chk #(.POWERUP_CYC(POWERUP_CYC)) u_chk (
  .core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .active_q(active_q),
  .deep_sleep_q(deep_sleep_q), .status_q(status_q),
  .modify_go_q(modify_go_q), .modify_op_q(modify_op_q),
  .refused_q(refused_q));

// File: verification/flash_host_model.sv
`timescale 1ns/1ps
// host side: mode 0, clock idles low and stands still between frames
module flash_host_model (
  output logic sclk,  // serial clock, 48 ns period
  output logic cs_n,  // select, active low
  output logic mosi   // serial data out
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // send top n bits, msb first; device samples on rising clock
  task send(input logic [39:0] bits, input int n);
    #7 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = bits[39-i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    #24 cs_n = 1'b1;
    // released line must not keep showing the last bit
    mosi = ~mosi;
  endtask : send
endmodule : flash_host_model

// File: verification/tb_serial_flash_write_protection.sv
`timescale 1ns/1ps
module tb_serial_flash_write_protection;
  import flash_wp_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, wp_n = 1'b1, cycle_done = 1'b0;
  logic sclk, cs_n, mosi, active_q, deep_sleep_q, modify_go_q, refused_q;
  logic [7:0] status_q, modify_op_q;
  logic [1:0] lock_rd_q;
  logic [ADDR_BITS-1:0] modify_addr_q;
  logic go_seen, ref_seen;  // sticky pulse catchers
  logic [31:0] lfsr_q = 32'h0000_0C24;
  logic [4:0] sec;
  int fails = 0, cmp_count = 0;
  initial forever #50 core_clk = ~core_clk;
  flash_write_guard #(.POWERUP_CYC(4)) u_dut (.core_clk(core_clk),
    .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n),
    .cycle_done(cycle_done), .active_q(active_q),
    .deep_sleep_q(deep_sleep_q), .status_q(status_q),
    .lock_rd_q(lock_rd_q), .modify_go_q(modify_go_q),
    .modify_op_q(modify_op_q), .modify_addr_q(modify_addr_q),
    .refused_q(refused_q));
  flash_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  always @(posedge core_clk) begin
    if (modify_go_q === 1'b1) go_seen = 1'b1;
    if (refused_q === 1'b1) ref_seen = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // range protection for {top_bottom_select, range code}
  function automatic logic prot(input logic [3:0] tr, input logic [4:0] s);
    logic [5:0] n;
    if (tr[2:0] == 3'h0) return 1'b0;
    if (tr[2:0] >= 3'h6) return 1'b1;
    n = 6'h01 << (tr[2:0] - 3'h1);
    if (tr[3]) return {1'b0, s} < n;
    return {1'b0, s} >= 6'h20 - n;
  endfunction : prot
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // one frame, then a deselect gap long enough for the core to answer
  task frame(input logic [39:0] bits, input int n);
    @(negedge core_clk);
    go_seen = 1'b0;
    ref_seen = 1'b0;
    u_host.send(bits, n);
    repeat (12) @(negedge core_clk);
  endtask : frame
  // unlock, then op; exp 1 start, 0 refuse, 2 anything but refuse
  task modify(input logic [39:0] bits, input int n, input int exp);
    frame({CMD_WRITE_UNLOCK, 32'h0}, 8);
    frame(bits, n);
    if (exp != 2) check(go_seen, exp == 1);
    check(ref_seen, exp == 0);
    cycle_done = 1'b1;
    @(negedge core_clk);
    cycle_done = 1'b0;
  endtask : modify
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    check(status_q, 8'h00);
    modify({CMD_PAGE_WRITE, 32'h0}, 31, 0);
    // a refused frame leaves the latch set, so lock it first
    frame({CMD_WRITE_LOCK, 32'h0}, 8);
    frame({CMD_PAGE_WRITE, 32'h0}, 32);
    check(ref_seen, 1);
    frame({CMD_WRITE_UNLOCK, 32'h0}, 8);
    check(status_q[1], 1);
    frame({CMD_WRITE_LOCK, 32'h0}, 8);
    check(status_q[1], 0);
    // started write keeps device active after deselect
    frame({CMD_WRITE_UNLOCK, 32'h0}, 8);
    frame({CMD_PAGE_WRITE, 24'h031234, 8'h00}, 32);
    check(go_seen, 1);
    check(modify_addr_q, 21'h031234);
    check(modify_op_q, CMD_PAGE_WRITE);
    check(status_q[1:0], 2'h1);
    check(active_q, 1);
    cycle_done = 1'b1;
    repeat (4) @(negedge core_clk);
    cycle_done = 1'b0;
    check(status_q[0], 0);
    check(active_q, 0);
    frame({CMD_SECTOR_LOCK_READ, 24'h030000, 8'h00}, 32);
    check(lock_rd_q, 2'h0);
    frame({CMD_DEEP_SLEEP, 32'h0}, 8);
    check(deep_sleep_q, 1);
    modify({CMD_PAGE_WRITE, 32'h0}, 32, 0);
    check(deep_sleep_q, 1);
    frame({CMD_WAKE_FROM_SLEEP, 32'h0}, 8);
    check(deep_sleep_q, 0);
    // sector 5: lock, then lock down for the rest of the run
    modify({CMD_SECTOR_LOCK_WRITE, 24'h050000, 8'h01}, 40, 2);
    frame({CMD_SECTOR_LOCK_READ, 24'h050000, 8'h00}, 32);
    check(lock_rd_q, 2'h1);
    modify({CMD_PAGE_WRITE, 24'h050000, 8'h00}, 32, 0);
    modify({CMD_SECTOR_LOCK_WRITE, 24'h050000, 8'h03}, 40, 2);
    modify({CMD_SECTOR_LOCK_WRITE, 24'h050000, 8'h00}, 40, 0);
    frame({CMD_SECTOR_LOCK_READ, 24'h050000, 8'h00}, 32);
    check(lock_rd_q, 2'h3);
    // every range code on both sides, random target sector except sector 5 at i == 3
    for (int i = 0; i < 16; i++) begin
      lfsr_q = lfsr(lfsr_q);
      sec = (i == 3) ? 5'h05 : lfsr_q[4:0];
      modify({CMD_STATUS_WRITE, 2'h0, i[3:0], 2'h0, 24'h0}, 16, 2);
      check(status_q[5:2], i[3:0]);
      modify({CMD_ERASE_4K, 3'h0, sec, lfsr_q[20:5], 8'h00}, 32,
        !(prot(i[3:0], sec) || sec == 5'h05));
    end
    modify({CMD_WHOLE_ARRAY_WIPE, 32'h0}, 8, 0);
    modify({CMD_STATUS_WRITE, 32'h0}, 16, 2);
    modify({CMD_WHOLE_ARRAY_WIPE, 32'h0}, 8, 1);
    // freeze only with freeze bit set and pin low
    modify({CMD_STATUS_WRITE, 8'h84, 24'h0}, 16, 2);
    check(status_q[7:2], 6'h21);
    wp_n = 1'b0;
    modify({CMD_STATUS_WRITE, 32'h0}, 16, 2);
    check(status_q[7:2], 6'h21);
    check(status_q[1], 0);
    wp_n = 1'b1;
    modify({CMD_STATUS_WRITE, 32'h0}, 16, 2);
    check(status_q[7:2], 6'h00);
    tally_and_finish;
  end
endmodule : tb_serial_flash_write_protection
